/* File: rtl/itm_pkg.sv */
package itm_pkg;

   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_PRELOAD   = 8'h08;
   localparam logic [7:0] ADDR_COUNT     = 8'h0c;
   localparam logic [7:0] ADDR_PORTC     = 8'h10;
   localparam logic [7:0] ADDR_VECTOR    = 8'h14;

   localparam int CNT_W = 24;
   localparam int PRE_W = 5;

   localparam logic [PRE_W-1:0] PRE_ONES = 5'h1f;
   localparam logic [PRE_W-1:0] PRE_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [7:0]       VEC_RST  = 8'h0f;
   localparam logic [7:0]       CTRL_RST = 8'h00;

   localparam int CTL_ENABLE = 0;
   localparam int CTL_CLK_LO = 1;
   localparam int CTL_CLK_HI = 2;
   localparam int CTL_ZDCTL  = 4;
   localparam int CTL_TO_LO  = 5;
   localparam int CTL_TO_HI  = 7;
   localparam int STS_ZDFLAG = 0;

   // Pin function, control bits 7:5.
   localparam logic [2:0] PIN_PORTC  = 3'h0;
   localparam logic [2:0] PIN_SQUARE = 3'h2;
   localparam logic [2:0] PIN_IRQ    = 3'h5;
   localparam logic [2:0] PIN_IRQ_B  = 3'h7;

   // Clock source, control bits 2:1.
   localparam logic [1:0] SRC_CLK_PRE = 2'h0;
   localparam logic [1:0] SRC_EN_PRE  = 2'h1;
   localparam logic [1:0] SRC_EXT_PRE = 2'h2;
   localparam logic [1:0] SRC_EXT_RAW = 2'h3;

   typedef enum logic [1:0] {
      ITM_HALT,
      ITM_LOAD,
      ITM_RUN
   } itm_phase_t;

   typedef struct packed {
      logic [7:0]       control;
      logic [CNT_W-1:0] preload;
      logic [CNT_W-1:0] counter;
      logic [PRE_W-1:0] prescale;
      logic [7:0]       vector;
      logic             zero_detect_flag;
      logic             square_level;
      logic             ext_prev;
      itm_phase_t       phase;
      logic             bus_pend;
      logic             bus_write;
      logic [7:0]       bus_addr;
      logic [31:0]      hrdata;
      logic             ack_out;
      logic [7:0]       ack_vec;
   } itm_state_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } itm_ahb_in_t;

endpackage

/* File: rtl/itm_timer.sv */
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module itm_timer (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire itm_pkg::itm_ahb_in_t ahb_in,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                timer_ext_input,
   input  wire logic                timer_ack_input,
   input  wire logic                portc_bit_three_in,
   output logic                     timer_output_pin,
   output logic                     timer_output_oe_n,
   output logic                     bus_transfer_ack,
   output logic [7:0]               ack_vector
);

   itm_pkg::itm_state_t st;
   itm_pkg::itm_state_t next_st;

   logic [2:0]  pin_fn;
   logic [1:0]  src;
   logic        running;
   logic        watchdog;
   logic        irq_mode;
   logic        tick;
   logic        pre_wrap;
   logic        ext_rise;
   logic        zero_hit;
   logic        timer_level;
   logic        clear_req;
   logic        wr_ctrl;
   logic [31:0] rd_word;

   assign pin_fn   = st.control[itm_pkg::CTL_TO_HI:itm_pkg::CTL_TO_LO];
   assign src      = st.control[itm_pkg::CTL_CLK_HI:itm_pkg::CTL_CLK_LO];
   assign irq_mode = (pin_fn == itm_pkg::PIN_IRQ) || (pin_fn == itm_pkg::PIN_IRQ_B);
   // Watchdog pairs the enable-gated source with the interrupt pin function.
   assign watchdog = irq_mode && (src == itm_pkg::SRC_EN_PRE);
   // External enable gates the run state.
   assign running  = st.control[itm_pkg::CTL_ENABLE]
                     && ((src != itm_pkg::SRC_EN_PRE) || timer_ext_input);
   assign ext_rise = timer_ext_input && !st.ext_prev;
   assign pre_wrap = running && (st.prescale == itm_pkg::PRE_ZERO);

   always_comb begin
      tick = 1'b0;
      if (running) begin
         case (src)
            itm_pkg::SRC_EXT_RAW: tick = ext_rise;
            itm_pkg::SRC_EXT_PRE: tick = ext_rise && (st.prescale == itm_pkg::PRE_ZERO);
            default:              tick = pre_wrap;
         endcase
      end
   end

   assign zero_hit = tick && (st.phase == itm_pkg::ITM_RUN)
                     && (st.counter == itm_pkg::CNT_ONE);
   assign timer_level = (pin_fn == itm_pkg::PIN_SQUARE) ? st.square_level
                        : (irq_mode && st.zero_detect_flag);
   assign wr_ctrl   = st.bus_pend && st.bus_write && (st.bus_addr == itm_pkg::ADDR_CONTROL);
   assign clear_req = st.bus_pend && st.bus_write && (st.bus_addr == itm_pkg::ADDR_STATUS)
                      && ahb_in.hwdata[itm_pkg::STS_ZDFLAG];

   always_comb begin
      rd_word = 32'h0000_0000;
      case (ahb_in.haddr[7:0])
         itm_pkg::ADDR_CONTROL: rd_word[7:0] = st.control;
         itm_pkg::ADDR_STATUS:  rd_word[itm_pkg::STS_ZDFLAG] = st.zero_detect_flag;
         itm_pkg::ADDR_PRELOAD: rd_word[itm_pkg::CNT_W-1:0] = st.preload;
         itm_pkg::ADDR_COUNT:   rd_word[itm_pkg::CNT_W-1:0] = st.counter;
         itm_pkg::ADDR_PORTC:   rd_word[0] = (pin_fn == itm_pkg::PIN_PORTC)
                                             ? portc_bit_three_in : timer_level;
         itm_pkg::ADDR_VECTOR:  rd_word[7:0] = st.vector;
         default:               rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.ext_prev = timer_ext_input;
      // Bus data phase completes in one cycle.
      next_st.bus_pend = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1];
      if (next_st.bus_pend) begin
         next_st.bus_write = ahb_in.hwrite;
         next_st.bus_addr  = ahb_in.haddr[7:0];
         if (!ahb_in.hwrite) begin
            next_st.hrdata = rd_word;
         end
      end
      if (st.bus_pend && st.bus_write) begin
         case (st.bus_addr)
            itm_pkg::ADDR_CONTROL: next_st.control = ahb_in.hwdata[7:0];
            itm_pkg::ADDR_PRELOAD: next_st.preload = ahb_in.hwdata[itm_pkg::CNT_W-1:0];
            itm_pkg::ADDR_VECTOR:  next_st.vector  = ahb_in.hwdata[7:0];
            default:               next_st.vector  = st.vector;
         endcase
      end
      // Square output sits high whenever the timer is not enabled.
      if (!st.control[itm_pkg::CTL_ENABLE] || wr_ctrl) begin
         next_st.square_level = 1'b1;
      end
      if (!running) begin
         next_st.prescale         = itm_pkg::PRE_ONES;
         next_st.zero_detect_flag = 1'b0;
         next_st.phase            = itm_pkg::ITM_LOAD;
      end else begin
         if ((src != itm_pkg::SRC_EXT_RAW)
             && ((src != itm_pkg::SRC_EXT_PRE) || ext_rise)) begin
            next_st.prescale = st.prescale - 5'h01;
         end
         if (tick) begin
            if (st.phase != itm_pkg::ITM_RUN) begin
               next_st.counter = st.preload;
               next_st.phase   = itm_pkg::ITM_RUN;
            end else if ((st.counter == itm_pkg::CNT_ZERO)
                         && !st.control[itm_pkg::CTL_ZDCTL]
                         && !watchdog) begin
               next_st.counter = st.preload;
            end else begin
               next_st.counter = st.counter - itm_pkg::CNT_ONE;
            end
         end
         if (clear_req) begin
            next_st.zero_detect_flag = 1'b0;
         end
         if (zero_hit) begin
            next_st.zero_detect_flag = 1'b1;
            if (pin_fn == itm_pkg::PIN_SQUARE) begin
               next_st.square_level = !st.square_level;
            end
         end
      end
      // Acknowledge answered only for an asserted interrupt request.
      next_st.ack_out = timer_ack_input && irq_mode && st.zero_detect_flag;
      next_st.ack_vec = next_st.ack_out ? st.vector : 8'h00;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st                  <= '0;
         st.control          <= itm_pkg::CTRL_RST;
         st.prescale         <= itm_pkg::PRE_ONES;
         st.vector           <= itm_pkg::VEC_RST;
         st.square_level     <= 1'b1;
         st.phase            <= itm_pkg::ITM_HALT;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata            = st.hrdata;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign timer_output_pin  = timer_level;
   assign timer_output_oe_n = (pin_fn == itm_pkg::PIN_PORTC);
   assign bus_transfer_ack  = st.ack_out;
   assign ack_vector        = st.ack_vec;

endmodule // itm_timer

/* File: tb/itm_ack_host.sv */
`timescale 1ns/1ps
module itm_ack_host (
   input  wire logic hclk,
   input  wire logic go,
   output logic      ack
);
   // Interrupt acknowledge logic raises the level one clock after being asked.
   always_ff @(posedge hclk) ack <= go;
endmodule // itm_ack_host

/* File: tb/itm_timer_checker.sv */
`timescale 1ns/1ps
module itm_timer_checker (
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire itm_pkg::itm_ahb_in_t ahb_in,
   input wire logic [31:0]          hrdata,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 timer_ext_input,
   input wire logic                 timer_ack_input,
   input wire logic                 portc_bit_three_in,
   input wire logic                 timer_output_pin,
   input wire logic                 timer_output_oe_n,
   input wire logic                 bus_transfer_ack,
   input wire logic [7:0]           ack_vector
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd(logic [31:0] a);
      ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1] && !ahb_in.hwrite && ahb_in.haddr == a;
   endsequence
   property p_ready; hreadyout && !hresp; endproperty
   a_ready: assert property (p_ready) else $error("bus stalled or errored");
   property p_rst_pin; !$past(hresetn) |-> timer_output_oe_n; endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("pin not port C after reset");
   property p_ack;
      bus_transfer_ack |-> $past(timer_ack_input) && $past(timer_output_pin)
         && !$past(timer_output_oe_n);
   endproperty
   a_ack: assert property (p_ack) else $error("ack without raised request");
   property p_ack_end; $fell(timer_ack_input) |-> ##2 !bus_transfer_ack; endproperty
   a_ack_end: assert property (p_ack_end) else $error("ack outlived request");
   property p_vec; !bus_transfer_ack |-> ack_vector == 8'h00; endproperty
   a_vec: assert property (p_vec) else $error("vector without ack");
   property p_oe; timer_output_oe_n |-> !bus_transfer_ack; endproperty
   a_oe: assert property (p_oe) else $error("ack while pin is port C");
   property p_portc;
      s_rd({24'h0, itm_pkg::ADDR_PORTC}) ##0 !timer_output_oe_n
         |=> hrdata[0] == $past(timer_output_pin);
   endproperty
   a_portc: assert property (p_portc) else $error("port C read lost output level");
   property p_pin_in;
      s_rd({24'h0, itm_pkg::ADDR_PORTC}) ##0 timer_output_oe_n
         |=> hrdata[0] == $past(portc_bit_three_in);
   endproperty
   a_pin_in: assert property (p_pin_in) else $error("port C read lost pin level");
   property p_unmap; s_rd(32'h40) |=> hrdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // itm_timer_checker

/* File: tb/itm_timer_tb.sv */
`timescale 1ns/1ps
module itm_timer_tb;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} itm_row_t;
   logic hclk = 0, hresetn = 0, sel = 0, wr = 0, ext = 0, go = 0, pc3 = 1;
   logic [31:0] ad = 0, wd = 0, r, hrdata;
   logic [1:0]  tr = 0;
   logic        rdy, hresp, ack, pin, oe_n, bta;
   logic [7:0]  av;
   int          err_count = 0, checks = 0;
   itm_row_t    rows [7];
   wire itm_pkg::itm_ahb_in_t ain = {sel, ad, tr, wr, 3'h2, rdy, wd};
   always #20 hclk = ~hclk;
   itm_timer itm_timer_i (.hclk(hclk), .hresetn(hresetn), .ahb_in(ain), .hrdata(hrdata),
      .hreadyout(rdy), .hresp(hresp), .timer_ext_input(ext), .timer_ack_input(ack),
      .portc_bit_three_in(pc3), .timer_output_pin(pin), .timer_output_oe_n(oe_n),
      .bus_transfer_ack(bta), .ack_vector(av));
   itm_ack_host itm_ack_host_i (.hclk(hclk), .go(go), .ack(ack));
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      sel <= 1; ad <= {24'h0, a}; tr <= 2'h2; wr <= w;
      do @(posedge hclk); while (rdy !== 1'b1);
      sel <= 0; tr <= 2'h0; wd <= d;
      do @(posedge hclk); while (rdy !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask
   task automatic wt(input logic v, input int n);
      repeat (n) begin
         if (pin === v) return;
         @(posedge hclk);
      end
   endtask
   task automatic mode(input logic [7:0] v);
      xf(1, itm_pkg::ADDR_CONTROL, 32'h0);
      xf(1, itm_pkg::ADDR_CONTROL, {24'h0, v});
   endtask
   task automatic results;
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #400000 err_count++;
      results;
   end
   initial begin
      rows = '{'{0, itm_pkg::ADDR_CONTROL, 0},
               '{0, itm_pkg::ADDR_VECTOR, 32'h0f},
               '{1, itm_pkg::ADDR_PRELOAD, 32'h5},
               '{0, itm_pkg::ADDR_PRELOAD, 32'h5},
               '{0, 8'h40, 0},
               '{0, itm_pkg::ADDR_STATUS, 0},
               '{0, itm_pkg::ADDR_PORTC, 1}};
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      foreach (rows[i]) begin
         xf(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("register", rows[i].d, r);
      end
      mode(8'ha1);
      wt(1, 400); chk("irq", 1, pin);
      repeat (300) @(posedge hclk); chk("irq held", 1, pin);
      xf(0, itm_pkg::ADDR_STATUS, 0); chk("flag", 1, r);
      go <= 1; repeat (4) @(posedge hclk); chk("ack", 1, bta); chk("vector", 8'h0f, av);
      go <= 0; xf(1, itm_pkg::ADDR_STATUS, 1); @(posedge hclk); chk("cleared", 0, pin);
      wt(1, 250); chk("reloaded", 1, pin);
      mode(8'h40); @(posedge hclk); chk("square idle", 1, pin);
      xf(1, itm_pkg::ADDR_CONTROL, 32'h41); wt(0, 400); chk("toggled", 0, pin);
      xf(0, itm_pkg::ADDR_PORTC, 0); chk("portc level", 0, r);
      go <= 1; repeat (4) @(posedge hclk); chk("square ack", 0, bta); go <= 0;
      xf(1, itm_pkg::ADDR_PRELOAD, 32'h2); mode(8'hb1); wt(1, 400);
      repeat (40) @(posedge hclk); xf(0, itm_pkg::ADDR_COUNT, 0); chk("wrap", 4'hf, r[23:20]);
      xf(1, itm_pkg::ADDR_PRELOAD, 32'ha); mode(8'h07);
      repeat (4) begin
         ext <= 1; repeat (4) @(posedge hclk); ext <= 0; repeat (4) @(posedge hclk);
      end
      xf(1, itm_pkg::ADDR_CONTROL, 32'h06); xf(0, itm_pkg::ADDR_COUNT, 0); chk("pulses", 7, r);
      xf(1, itm_pkg::ADDR_PRELOAD, 32'h5); mode(8'ha3);
      ext <= 1; repeat (50) @(posedge hclk); ext <= 0; repeat (2) @(posedge hclk);
      chk("watch early", 0, pin);
      ext <= 1;
      wt(1, 400);
      chk("watch late", 1, pin);
      repeat (40) @(posedge hclk);
      xf(0, itm_pkg::ADDR_COUNT, 0);
      chk("watch wrap", 4'hf, r[23:20]);
      ext <= 0; repeat (3) @(posedge hclk); chk("watch drop", 0, pin);
      xf(0, itm_pkg::ADDR_STATUS, 0); chk("watch flag", 0, r);
      hresetn <= 0; repeat (2) @(posedge hclk); hresetn <= 1; @(posedge hclk);
      xf(0, itm_pkg::ADDR_CONTROL, 0); chk("control reset", 0, r);
      results;
   end
endmodule // itm_timer_tb
bind itm_timer itm_timer_checker itm_timer_checker_i (.*);
